// file: design/svbs_pkg.sv
// Constants, types and timing for the brake, ready and thermal supervisor
//
// Behaviour
// - The holding brake follows the received drive enable bit and the chosen error reaction.
// - A one-to-zero fall of drive enable cuts torque and engages the brake at once.
// - The ready contact opens whenever any drive error is present.
// - The ready contact is closed only while error-free and the link is in phase four.
// - With control voltage and no error, the display shows the ready-for-power-up code.
// - With mains on, the display changes to the ready-for-power-output code.
// - Drive enable turns on the control loops, which then track the command value.
// - Amplifier and motor temperature are watched as two independent channels.
// - An overtemperature gives a warning that lasts a fixed 30 s before escalating.
// - The warning flashes code 50 or 51 and is reported to the controller.
// - When the warning expires, code 18 or 19 holds until reset and the error reaction runs.
// - The undelayed reaction removes torque, engages the brake and opens the ready contact.
// - The default reaction brakes under velocity control, then drops torque 500 ms later.
package svbs_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int WARN_S = 30;
   localparam int STOP_MS = 500;
   localparam logic [31:0] WARN_CYC = 32'(WARN_S * CLK_HZ);
   localparam logic [31:0] STOP_CYC = 32'(STOP_MS * (CLK_HZ / 1000));
   localparam logic [2:0] PHASE_RUN = 3'h4;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_STAT = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0C;
   // Control fields and reset values
   localparam int CTRL_REACT_LSB = 0;
   localparam int CTRL_BRAKE_BIT = 2;
   localparam int CTRL_CLR_BIT = 3;
   localparam logic [1:0] RST_REACT = 2'h0;
   localparam logic RST_BRAKE_FITTED = 1'b1;
   localparam logic [4:0] RST_INT_MASK = 5'h00;
   localparam int NUM_EVENTS = 5;
   // Display codes; letters are shown as hex look-alikes
   localparam logic [7:0] DISP_BLANK = 8'h00;
   localparam logic [7:0] DISP_POWER_UP = 8'hBB;
   localparam logic [7:0] DISP_POWER_OUT = 8'hAB;
   localparam logic [7:0] DISP_AMP_WARN = 8'h50;
   localparam logic [7:0] DISP_MOT_WARN = 8'h51;
   localparam logic [7:0] DISP_AMP_SHUT = 8'h18;
   localparam logic [7:0] DISP_MOT_SHUT = 8'h19;
   localparam logic [7:0] DISP_EXT_ERR = 8'hEE;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_RUN = 4'h2,
      ST_DECEL = 4'h4,
      ST_FAULT = 4'h8
   } svbs_state_t;
   typedef enum logic [1:0] {
      REACT_FULL = 2'h0,
      REACT_LOCAL = 2'h1,
      REACT_UNDELAYED = 2'h2,
      REACT_LATE = 2'h3
   } svbs_react_t;
   typedef struct packed {
      logic ctrl_voltage;
      logic mains_on;
      logic amp_hot;
      logic motor_hot;
   } svbs_pins_t;
endpackage

// file: design/svbs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module svbs_sync
   import svbs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pin and filtered level
   input wire logic pin,
   output logic level
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_ff <= 1'b0;
      end else if (s2_ff == s3_ff) begin
         level_ff <= s3_ff;
      end
   end

   assign level = level_ff;
endmodule

// file: design/svbs_thermal.sv
// One temperature channel: timed warning escalating to a latched shutdown
`timescale 1ns/1ps
module svbs_thermal
   import svbs_pkg::*;
#(
   parameter logic [31:0] WARN_CYCLES = WARN_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sensor and error reset
   input wire logic hot,
   input wire logic clear,
   // Status
   output logic warn,
   output logic shutdown
);
   logic [31:0] cnt_ff;
   logic warn_ff;
   logic shut_ff;

   // Warning runs for a fixed interval; cooling down cancels it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 32'h0000_0000;
         warn_ff <= 1'b0;
      end else if (hot && !shut_ff && cnt_ff != WARN_CYCLES) begin
         cnt_ff <= cnt_ff + 32'h1;
         warn_ff <= 1'b1;
      end else begin
         cnt_ff <= 32'h0000_0000;
         warn_ff <= 1'b0;
      end
   end

   // Expiry wins over a reset in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shut_ff <= 1'b0;
      end else if (hot && !shut_ff && cnt_ff == WARN_CYCLES) begin
         shut_ff <= 1'b1;
      end else if (clear) begin
         shut_ff <= 1'b0;
      end
   end

   assign warn = warn_ff;
   assign shutdown = shut_ff;

   chk_shut_after_warn: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(shut_ff) |-> $past(warn_ff) && $past(cnt_ff) == WARN_CYCLES)
      else $error("shutdown without a full warning interval");
endmodule

// file: design/svbs_supervisor.sv
// Brake, ready contact, display and thermal supervisor with AXI4-Lite registers
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module svbs_supervisor
   import svbs_pkg::*;
#(
   parameter logic [31:0] WARN_CYCLES = WARN_CYC,
   parameter logic [31:0] STOP_CYCLES = STOP_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Drive link, same clock
   input wire logic drive_enable,
   input wire logic [2:0] comm_phase,
   input wire logic nc_error_reset,
   input wire logic ext_error,
   input wire logic [15:0] command_value,
   // Pins from outside the clock domain
   input wire svbs_pins_t pins,
   // Drive outputs
   output logic torque_enable,
   output logic brake_engage,
   output logic velocity_brake,
   output logic loop_enable,
   output logic [15:0] command_out,
   output logic supply_error,
   output logic ready_relay_contact,
   output logic [7:0] status_display,
   output logic display_flash,
   output logic warn_to_nc,
   output logic irq
);
   svbs_pins_t pin_lvl;
   svbs_state_t state_ff;
   svbs_state_t nxt_state;
   logic [31:0] stop_cnt_ff;
   logic [1:0] react_ff;
   logic brake_fitted_ff;
   logic sw_clr_ff;
   logic [4:0] int_stat_ff;
   logic [4:0] int_mask_ff;
   logic [4:0] events;
   logic [4:0] prev_ff;
   logic irq_ff;
   logic torque_ff;
   logic brake_ff;
   logic vbrake_ff;
   logic loop_ff;
   logic [15:0] cmd_ff;
   logic supply_ff;
   logic ready_ff;
   logic [7:0] disp_ff;
   logic [7:0] nxt_disp;
   logic flash_ff;
   logic warn_amp;
   logic warn_mot;
   logic shut_amp;
   logic shut_mot;
   logic err_now;
   logic clr_err;
   logic phase_ok;
   logic aw_got_ff;
   logic w_got_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic wstrb0_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic do_write;
   logic rd_take;
   logic [2:0] wsel;
   logic [2:0] rsel;

   // Register index from a byte address; 3'h7 marks an unmapped address
   function automatic logic [2:0] reg_sel(input logic [7:0] addr);
      if (addr == OFS_CTRL) begin
         return 3'h0;
      end else if (addr == OFS_STATUS) begin
         return 3'h1;
      end else if (addr == OFS_INT_STAT) begin
         return 3'h2;
      end else if (addr == OFS_INT_MASK) begin
         return 3'h3;
      end else begin
         return 3'h7;
      end
   endfunction

   // Pin synchronisers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         svbs_sync u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin(pins[gi]),
            .level(pin_lvl[gi])
         );
      end
   endgenerate

   // Two independent temperature channels
   svbs_thermal #(.WARN_CYCLES(WARN_CYCLES)) u_amp (
      .aclk(aclk),
      .aresetn(aresetn),
      .hot(pin_lvl.amp_hot),
      .clear(clr_err),
      .warn(warn_amp),
      .shutdown(shut_amp)
   );
   svbs_thermal #(.WARN_CYCLES(WARN_CYCLES)) u_mot (
      .aclk(aclk),
      .aresetn(aresetn),
      .hot(pin_lvl.motor_hot),
      .clear(clr_err),
      .warn(warn_mot),
      .shutdown(shut_mot)
   );

   assign clr_err = nc_error_reset | sw_clr_ff;
   assign err_now = shut_amp | shut_mot | ext_error;
   assign phase_ok = (comm_phase == PHASE_RUN);

   // Drive state; enable loss beats every other transition
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            if (err_now) begin
               nxt_state = ST_FAULT;
            end else if (drive_enable && phase_ok && pin_lvl.mains_on) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!drive_enable) begin
               nxt_state = ST_OFF;
            end else if (err_now && react_ff == REACT_UNDELAYED) begin
               nxt_state = ST_FAULT;
            end else if (err_now) begin
               nxt_state = ST_DECEL;
            end
         end
         ST_DECEL: begin
            if (!drive_enable) begin
               nxt_state = ST_OFF;
            end else if (stop_cnt_ff == STOP_CYCLES - 32'h1) begin
               nxt_state = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (!err_now) begin
               nxt_state = ST_OFF;
            end
         end
         default: nxt_state = ST_FAULT;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= ST_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stop_cnt_ff <= 32'h0000_0000;
      end else if (state_ff == ST_DECEL) begin
         stop_cnt_ff <= stop_cnt_ff + 32'h1;
      end else begin
         stop_cnt_ff <= 32'h0000_0000;
      end
   end

   // Drive outputs follow the next state so they move with the transition
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         torque_ff <= 1'b0;
         brake_ff <= 1'b1;
         vbrake_ff <= 1'b0;
         loop_ff <= 1'b0;
         supply_ff <= 1'b0;
      end else begin
         torque_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_DECEL);
         // Brake held closed whenever torque is off, if one is fitted
         brake_ff <= brake_fitted_ff && (nxt_state == ST_OFF || nxt_state == ST_FAULT);
         vbrake_ff <= (nxt_state == ST_DECEL);
         loop_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_DECEL);
         supply_ff <= (react_ff == REACT_FULL) && (nxt_state == ST_DECEL || nxt_state == ST_FAULT);
      end
   end

   // Command tracking; during braking the velocity target is zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_ff <= 16'h0000;
      end else if (state_ff == ST_RUN) begin
         cmd_ff <= command_value;
      end else begin
         cmd_ff <= 16'h0000;
      end
   end

   // Ready contact closes only error-free in phase four
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= pin_lvl.ctrl_voltage && !err_now && phase_ok;
      end
   end

   // Display; shutdown beats warning beats readiness
   always_comb begin
      nxt_disp = DISP_BLANK;
      if (shut_amp) begin
         nxt_disp = DISP_AMP_SHUT;
      end else if (shut_mot) begin
         nxt_disp = DISP_MOT_SHUT;
      end else if (warn_amp) begin
         nxt_disp = DISP_AMP_WARN;
      end else if (warn_mot) begin
         nxt_disp = DISP_MOT_WARN;
      end else if (ext_error) begin
         nxt_disp = DISP_EXT_ERR;
      end else if (pin_lvl.ctrl_voltage && pin_lvl.mains_on) begin
         nxt_disp = DISP_POWER_OUT;
      end else if (pin_lvl.ctrl_voltage) begin
         nxt_disp = DISP_POWER_UP;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_ff <= DISP_BLANK;
         flash_ff <= 1'b0;
      end else begin
         disp_ff <= nxt_disp;
         flash_ff <= !shut_amp && !shut_mot && (warn_amp || warn_mot);
      end
   end

   // Interrupt events, sticky until the status read; a new event wins
   assign events = {
      prev_ff[4] & ~drive_enable,
      shut_mot & ~prev_ff[3],
      shut_amp & ~prev_ff[2],
      warn_mot & ~prev_ff[1],
      warn_amp & ~prev_ff[0]
   };

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff <= 5'h00;
         int_stat_ff <= 5'h00;
         irq_ff <= 1'b0;
      end else begin
         prev_ff <= {drive_enable, shut_mot, shut_amp, warn_mot, warn_amp};
         if (rd_take && rsel == 3'h2) begin
            int_stat_ff <= events;
         end else begin
            int_stat_ff <= int_stat_ff | events;
         end
         irq_ff <= |(int_stat_ff & int_mask_ff);
      end
   end

   // AXI write: address and data taken in either order
   assign s_axi_awready = !aw_got_ff && !bvalid_ff;
   assign s_axi_wready = !w_got_ff && !bvalid_ff;
   assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
   assign wsel = reg_sel(awaddr_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb0_ff <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= (wsel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Writable registers; only byte lane 0 carries fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         react_ff <= RST_REACT;
         brake_fitted_ff <= RST_BRAKE_FITTED;
         int_mask_ff <= RST_INT_MASK;
         sw_clr_ff <= 1'b0;
      end else begin
         sw_clr_ff <= 1'b0;
         if (do_write && wstrb0_ff && wsel == 3'h0) begin
            react_ff <= wdata_ff[CTRL_REACT_LSB +: 2];
            brake_fitted_ff <= wdata_ff[CTRL_BRAKE_BIT];
            sw_clr_ff <= wdata_ff[CTRL_CLR_BIT];
         end
         if (do_write && wstrb0_ff && wsel == 3'h3) begin
            int_mask_ff <= wdata_ff[NUM_EVENTS-1:0];
         end
      end
   end

   // AXI read: one cycle to rvalid
   assign s_axi_arready = !rvalid_ff;
   assign rd_take = s_axi_arvalid && !rvalid_ff;
   assign rsel = reg_sel(s_axi_araddr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OKAY;
         if (rsel == 3'h0) begin
            rdata_ff <= {28'h0, 1'b0, brake_fitted_ff, react_ff};
         end else if (rsel == 3'h1) begin
            rdata_ff <= {16'h0, disp_ff, warn_to_nc, torque_ff, brake_ff, ready_ff, state_ff};
         end else if (rsel == 3'h2) begin
            rdata_ff <= {27'h0, int_stat_ff};
         end else if (rsel == 3'h3) begin
            rdata_ff <= {27'h0, int_mask_ff};
         end else begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign torque_enable = torque_ff;
   assign brake_engage = brake_ff;
   assign velocity_brake = vbrake_ff;
   assign loop_enable = loop_ff;
   assign command_out = cmd_ff;
   assign supply_error = supply_ff;
   assign ready_relay_contact = ready_ff;
   assign status_display = disp_ff;
   assign display_flash = flash_ff;
   assign warn_to_nc = flash_ff;
   assign irq = irq_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_enable_fall_brake: assert property (
      state_ff == ST_RUN && !drive_enable ##1 brake_fitted_ff |-> !torque_ff && brake_ff)
      else $error("enable fall did not cut torque and close brake");
   chk_ready_error_open: assert property (
      err_now |=> !ready_relay_contact)
      else $error("ready contact closed during error");
   chk_ready_phase: assert property (
      ready_relay_contact |-> $past(comm_phase) == PHASE_RUN && !$past(err_now))
      else $error("ready contact closed outside phase four");
   chk_disp_power_up: assert property (
      pin_lvl.ctrl_voltage && !pin_lvl.mains_on && !err_now && !warn_amp && !warn_mot
      |=> status_display == DISP_POWER_UP)
      else $error("ready-for-power-up code missing");
   chk_disp_power_out: assert property (
      pin_lvl.ctrl_voltage && pin_lvl.mains_on && !err_now && !warn_amp && !warn_mot
      |=> status_display == DISP_POWER_OUT)
      else $error("ready-for-power-output code missing");
   chk_loop_tracks: assert property (
      state_ff == ST_RUN |=> command_out == $past(command_value))
      else $error("command not tracked while running");
   chk_warn_code: assert property (
      warn_amp && !shut_amp && !shut_mot |=> status_display == DISP_AMP_WARN && warn_to_nc)
      else $error("amplifier warning not shown or reported");
   chk_shut_code_hold: assert property (
      shut_mot && !shut_amp && !clr_err |=> status_display == DISP_MOT_SHUT)
      else $error("motor shutdown code not held");
   chk_undelayed_stop: assert property (
      state_ff == ST_RUN && drive_enable && err_now && react_ff == REACT_UNDELAYED
      |=> !torque_enable ##1 !ready_relay_contact)
      else $error("undelayed reaction kept torque or ready");
   chk_decel_window: assert property (
      state_ff == ST_DECEL |-> stop_cnt_ff < STOP_CYCLES && velocity_brake && torque_enable)
      else $error("velocity braking window wrong");
   chk_shut_priority: assert property (
      shut_amp |=> status_display == DISP_AMP_SHUT && !display_flash)
      else $error("shutdown code lost priority");
endmodule

// file: sim/svbs_nc_model.sv
// Numerical controller model on the far side of the drive link
`timescale 1ns/1ps
module svbs_nc_model
   import svbs_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench requests and drive feedback
   input wire logic run_req,
   input wire logic [2:0] phase_req,
   input wire logic clr_req,
   input wire logic warn_in,
   // Link to the drive
   output logic drive_enable,
   output logic [2:0] comm_phase,
   output logic nc_error_reset,
   output logic [15:0] command_value
);
   // Speed ramps down before enable drops, so the brake never meets a turning shaft
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_enable <= 1'b0;
         comm_phase <= 3'h0;
         nc_error_reset <= 1'b0;
         command_value <= 16'h0000;
      end else begin
         comm_phase <= phase_req;
         nc_error_reset <= clr_req;
         if (run_req && !warn_in) begin
            drive_enable <= 1'b1;
            command_value <= 16'h0400;
         end else if (command_value != 16'h0000) begin
            command_value <= command_value - 16'h0100;
         end else begin
            drive_enable <= 1'b0;
         end
      end
   end
endmodule

// file: sim/svbs_supervisor_tb_top.sv
// Self-checking bench for the supervisor
`timescale 1ns/1ps
module svbs_supervisor_tb_top import svbs_pkg::*;;
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wr, bv, arr, rv, de, ncr, tq, bk, vb, le, se, rdy, fl, wn, irq;
   logic run = 0, clr = 0, ext = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00, disp;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] bresp, rresp;
   logic [2:0] ph = 3'h0, cph;
   logic [15:0] cv, co;
   svbs_pins_t pins = 4'h8;
   int error_cnt = 0;
   int total_checks = 0;

   // Short counts keep the run brief
   svbs_supervisor #(.WARN_CYCLES(32'h14), .STOP_CYCLES(32'h8)) u_svbs_supervisor (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .drive_enable(de),
      .comm_phase(cph), .nc_error_reset(ncr), .ext_error(ext), .command_value(cv),
      .pins(pins), .torque_enable(tq), .brake_engage(bk), .velocity_brake(vb),
      .loop_enable(le), .command_out(co), .supply_error(se), .ready_relay_contact(rdy),
      .status_display(disp), .display_flash(fl), .warn_to_nc(wn), .irq(irq));

   svbs_nc_model u_svbs_nc_model (.aclk(aclk), .aresetn(aresetn), .run_req(run),
      .phase_req(ph), .clr_req(clr), .warn_in(wn), .drive_enable(de), .comm_phase(cph),
      .nc_error_reset(ncr), .command_value(cv));

   initial begin
      forever #12.5 aclk = ~aclk;
   end

   task test_done;
      if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge aclk);
   endtask

   // Handshakes are judged on values that stand before the sampling edge
   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      int n;
      n = 0;
      tb = 0;
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!tb && n < 40) begin
         @(negedge aclk);
         ta = awv && awr;
         tw = wv && wr;
         tb = bv && br;
         r = bresp;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) br <= 1'b0;
         n++;
      end
      if (!tb) error_cnt++;
      if (!tb) test_done();
      chk("bresp", 32'(er), 32'(r));
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, tb;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      tb = 0;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      while (!tb && n < 40) begin
         @(negedge aclk);
         ta = arv && arr;
         tb = rv && rr;
         d = rd;
         r = rresp;
         @(posedge aclk);
         if (ta) arv <= 1'b0;
         if (tb) rr <= 1'b0;
         n++;
      end
      if (!tb) error_cnt++;
      if (!tb) test_done();
      chk("rdata", e, d);
      chk("rresp", 32'(er), 32'(r));
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      test_done();
   end

   initial begin
      int n;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      cyc(8);
      chk("out", 32'h4, 32'({tq, bk, rdy, le}));
      chk("disp", 32'(DISP_POWER_UP), 32'(disp));
      rdchk(OFS_STATUS, 32'hBB21, RESP_OKAY);
      axw(8'h10, 32'h1, RESP_SLVERR);
      rdchk(OFS_CTRL, 32'h4, RESP_OKAY);
      rdchk(8'h10, 32'h0, RESP_SLVERR);
      @(posedge aclk);
      pins.mains_on <= 1'b1;
      ph <= PHASE_RUN;
      cyc(8);
      chk("out", 32'h6, 32'({tq, bk, rdy, le}));
      chk("disp", 32'(DISP_POWER_OUT), 32'(disp));
      @(posedge aclk);
      run <= 1'b1;
      cyc(10);
      chk("out", 32'hB, 32'({tq, bk, rdy, le}));
      chk("cmd", 32'h400, 32'(co));
      @(posedge aclk);
      run <= 1'b0;
      n = 0;
      while (de && n < 40) begin
         cyc(1);
         n++;
      end
      cyc(1);
      chk("out", 32'h6, 32'({tq, bk, rdy, le}));
      chk("irq", 32'h0, 32'(irq));
      axw(OFS_INT_MASK, 32'h1F, RESP_OKAY);
      cyc(2);
      chk("irq", 32'h1, 32'(irq));
      rdchk(OFS_INT_STAT, 32'h10, RESP_OKAY);
      cyc(2);
      chk("irq", 32'h0, 32'(irq));
      @(posedge aclk);
      ph <= 3'h3;
      cyc(4);
      chk("rdy", 32'h0, 32'(rdy));
      @(posedge aclk);
      ph <= PHASE_RUN;
      // Undelayed reaction first, then timed velocity braking
      for (int k = 0; k < 3; k++) begin
         axw(OFS_CTRL, (k == 0) ? 32'h6 : (k == 1) ? 32'h4 : 32'h5, RESP_OKAY);
         @(posedge aclk);
         run <= 1'b1;
         cyc(10);
         @(posedge aclk);
         ext <= 1'b1;
         cyc(2);
         chk("react", (k == 0) ? 32'h4 : (k == 1) ? 32'hB : 32'hA, 32'({tq, bk, vb, se}));
         cyc(5);
         chk("tq", 32'(k != 0), 32'(tq));
         cyc(6);
         chk("out", 32'h4, 32'({tq, bk, rdy, vb}));
         chk("disp", 32'(DISP_EXT_ERR), 32'(disp));
         @(posedge aclk);
         ext <= 1'b0;
         run <= 1'b0;
         cyc(12);
      end
      // Amplifier channel, then motor channel
      for (int ch = 0; ch < 2; ch++) begin
         @(posedge aclk);
         run <= 1'b1;
         cyc(10);
         @(posedge aclk);
         pins[1 - ch] <= 1'b1;
         n = 0;
         for (int i = 1; i <= 32; i++) begin
            cyc(1);
            if (fl) n++;
            if (i == 12) begin
               chk("disp", 32'(DISP_AMP_WARN) + 32'(ch), 32'(disp));
               chk("warn", 32'h3, 32'({fl, wn}));
            end
         end
         chk("warn_len", 32'h14, 32'(n));
         chk("disp", 32'(DISP_AMP_SHUT) + 32'(ch), 32'(disp));
         chk("rdy", 32'h0, 32'(rdy));
         @(posedge aclk);
         pins[1 - ch] <= 1'b0;
         run <= 1'b0;
         cyc(8);
         chk("disp", 32'(DISP_AMP_SHUT) + 32'(ch), 32'(disp));
         if (ch == 0) begin
            @(posedge aclk);
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
         end else begin
            axw(OFS_CTRL, 32'hC, RESP_OKAY);
         end
         cyc(8);
         chk("out", 32'h6, 32'({tq, bk, rdy, le}));
      end
      test_done();
   end
endmodule
